//--- ddrpi_pkg.sv
// Constants for the x16 double-data-rate memory pin interface.
// Assumes command pins are active low and sampled on the link clock's rising crossing.
package ddrpi_pkg;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int DQ_W   = 16;
	localparam int NBANKS = 4;

	// Command code is {chip select, row strobe, column strobe, write strobe}, all active low
	localparam logic [3:0] CMD_MODE_SET  = 4'h0;
	localparam logic [3:0] CMD_REFRESH   = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
	localparam logic [3:0] CMD_WRITE     = 4'h4;
	localparam logic [3:0] CMD_READ      = 4'h5;

	localparam logic [1:0] SEL_BASE_MODE = 2'h0;
	localparam logic [1:0] SEL_EXT_ONE   = 2'h1;

	localparam int PRECHARGE_ALL_BIT = 10;
	localparam int AUTO_PRE_BIT      = 10;
	localparam int COL_W             = 9;
	localparam int EXT_SINGLE_BIT    = 10;
	localparam int EXT_TERM_LO_BIT   = 2;
	localparam int EXT_TERM_HI_BIT   = 6;
	localparam int MODE_BURST_LSB    = 0;
	localparam int MODE_BURST_W      = 3;

	localparam logic [2:0]        BURST_CODE_8  = 3'h3;
	localparam logic [3:0]        BURST_BEATS_4 = 4'h4;
	localparam logic [3:0]        BURST_BEATS_8 = 4'h8;
	localparam logic [ADDR_W-1:0] MODE_RESET    = 13'h0000;
	localparam logic [ADDR_W-1:0] EXT_RESET     = 13'h0000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b10
	} ddrpi_state_t;
endpackage

//--- ddrpi_fifo.sv
// Flip-flop FIFO holding stored write beats.
// Assumes one clock; both sides use valid/ready.
`timescale 1ns/1ps
module ddrpi_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	wire              full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	wire              empty_w = (wr_ptr_reg == rd_ptr_reg);
	wire              push_w  = in_valid && !full_w;
	wire              pop_w   = out_valid && out_ready;

	assign in_ready  = !full_w;
	assign out_valid = !empty_w;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push_w)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop_w)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push_w)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
	end
endmodule

//--- ddrpi_pin_interface.sv
// Device-side pin logic: command decode, mode registers, bank state, termination, data strobes.
// Assumes all pins come from the link clock domain and are sampled here through two flip-flops.
`timescale 1ns/1ps
module ddrpi_pin_interface
	import ddrpi_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ck_pin,
	input  wire logic              cke_pin,
	input  wire logic              cs_n_pin,
	input  wire logic              ras_n_pin,
	input  wire logic              cas_n_pin,
	input  wire logic              we_n_pin,
	input  wire logic [BANK_W-1:0] bank_select,
	input  wire logic [ADDR_W-1:0] addr_pin,
	input  wire logic              termination_control,
	input  wire logic              lower_byte_write_mask,
	input  wire logic              upper_byte_write_mask,
	input  wire logic [DQ_W-1:0]   dq_in,
	output logic      [DQ_W-1:0]   dq_out,
	output logic                   dq_oe,
	input  wire logic              lower_data_strobe_in,
	output logic                   lower_data_strobe_out,
	output logic                   lower_data_strobe_oe,
	input  wire logic              lower_data_strobe_n_in,
	output logic                   lower_data_strobe_n_out,
	output logic                   lower_data_strobe_n_oe,
	input  wire logic              upper_data_strobe_in,
	output logic                   upper_data_strobe_out,
	output logic                   upper_data_strobe_oe,
	input  wire logic              upper_data_strobe_n_in,
	output logic                   upper_data_strobe_n_out,
	output logic                   upper_data_strobe_n_oe,
	output logic                   termination_on,
	output logic      [NBANKS-1:0] bank_open,
	output logic      [ADDR_W-1:0] mode_value,
	output logic      [ADDR_W-1:0] ext_one_value,
	output logic      [COL_W-1:0]  burst_column,
	output logic                   store_ready,
	output logic                   wr_valid,
	input  wire logic              wr_ready,
	output logic      [DQ_W-1:0]   wr_data,
	output logic      [1:0]        wr_byte_en,
	input  wire logic [DQ_W-1:0]   rd_data,
	output logic                   rd_next
);
	localparam int SW = 9 + BANK_W + ADDR_W + 3 + DQ_W + 4;

	// Two-stage synchroniser for every pin; only stage two is read
	logic [SW-1:0] pin_s1_reg;
	logic [SW-1:0] pin_s2_reg;
	wire  [SW-1:0] pin_vec = {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
		bank_select, addr_pin, termination_control, lower_byte_write_mask, upper_byte_write_mask,
		dq_in, lower_data_strobe_in, lower_data_strobe_n_in, upper_data_strobe_in,
		upper_data_strobe_n_in, 3'h0};

	always_ff @(posedge clk)
	begin
		pin_s1_reg <= pin_vec;
		pin_s2_reg <= pin_s1_reg;
	end

	wire              ck_s, cke_s, cs_s, odt_s, lmask_s, umask_s, ls_s, lsn_s, us_s, usn_s;
	wire [3:0]        cmd_s;
	wire [BANK_W-1:0] ba_s;
	wire [ADDR_W-1:0] addr_s;
	wire [DQ_W-1:0]   dq_s;
	wire [2:0]        pad_s;
	assign {ck_s, cke_s, cmd_s, ba_s, addr_s, odt_s, lmask_s, umask_s, dq_s,
		ls_s, lsn_s, us_s, usn_s, pad_s} = pin_s2_reg;
	assign cs_s = cmd_s[3];

	ddrpi_state_t      state_reg;
	logic              ck_prev_reg;
	logic              ls_prev_reg;
	logic              us_prev_reg;
	logic [ADDR_W-1:0] mode_reg;
	logic [ADDR_W-1:0] ext_reg;
	logic              term_reg;
	logic [NBANKS-1:0] open_reg;
	logic [3:0]        beat_reg;
	logic [COL_W-1:0]  col_reg;
	logic              lo_seen_reg, hi_seen_reg, lo_mask_reg, hi_mask_reg;
	logic [7:0]        lo_hold_reg, hi_hold_reg;
	logic              strobe_reg, strobe_oe_reg, strobe_n_oe_reg, dq_oe_reg, rd_next_reg, store_ready_reg;
	logic [DQ_W-1:0]   dq_out_reg;
	wire               fifo_in_ready;

	// Rising crossing of the true clock takes a command; either crossing moves read data
	wire ck_rise   = ck_s && !ck_prev_reg;
	wire ck_edge   = ck_s != ck_prev_reg;
	wire cmd_take  = ck_rise && cke_s && !cs_s;
	wire is_mode   = cmd_take && (cmd_s == CMD_MODE_SET);
	wire is_pre    = cmd_take && (cmd_s == CMD_PRECHARGE);
	wire is_act    = cmd_take && (cmd_s == CMD_ACTIVATE);
	wire is_wr     = cmd_take && (cmd_s == CMD_WRITE) && (state_reg == ST_IDLE);
	wire is_rd     = cmd_take && (cmd_s == CMD_READ) && (state_reg == ST_IDLE);
	wire pre_all   = addr_s[PRECHARGE_ALL_BIT];
	wire auto_pre  = addr_s[AUTO_PRE_BIT];
	wire term_en   = ext_reg[EXT_TERM_LO_BIT] || ext_reg[EXT_TERM_HI_BIT];
	wire single_se = ext_reg[EXT_SINGLE_BIT];
	wire [3:0] burst_len = (mode_reg[MODE_BURST_LSB +: MODE_BURST_W] == BURST_CODE_8) ? BURST_BEATS_8 : BURST_BEATS_4;

	// Differential strobe is read as a crossing of the pair
	wire ls_lvl  = single_se ? ls_s : (ls_s && !lsn_s);
	wire us_lvl  = single_se ? us_s : (us_s && !usn_s);
	wire in_wr   = state_reg == ST_WRITE;
	wire lo_edge = in_wr && (ls_lvl != ls_prev_reg);
	wire hi_edge = in_wr && (us_lvl != us_prev_reg);
	wire lo_seen = lo_seen_reg || lo_edge;
	wire hi_seen = hi_seen_reg || hi_edge;
	wire [7:0] lo_byte = lo_edge ? dq_s[7:0] : lo_hold_reg;
	wire [7:0] hi_byte = hi_edge ? dq_s[15:8] : hi_hold_reg;
	wire lo_m    = lo_edge ? lmask_s : lo_mask_reg;
	wire hi_m    = hi_edge ? umask_s : hi_mask_reg;
	wire beat_take = lo_seen && hi_seen;
	wire [1:0] byte_en = {!hi_m, !lo_m};
	wire push_w  = beat_take && (byte_en != 2'h0);
	wire wr_last = beat_take && (beat_reg == burst_len - 4'h1);

	wire in_rd   = state_reg == ST_READ;
	wire rd_beat = in_rd && ck_edge && (beat_reg < burst_len);
	wire rd_end  = in_rd && ck_edge && (beat_reg == burst_len);

	// Disabling termination in the mode register overrides the control at once
	wire term_next = ck_rise ? (odt_s && term_en) : (term_reg && term_en);

	logic [NBANKS-1:0] open_next;
	genvar b;
	generate
		for (b = 0; b < NBANKS; b++)
		begin : g_bank
			wire sel = ba_s == BANK_W'(b);
			assign open_next[b] = (is_act && sel) ? 1'b1 :
				(is_pre && (pre_all || sel)) ? 1'b0 :
				((is_wr || is_rd) && sel && auto_pre) ? 1'b0 : open_reg[b];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ck_prev_reg <= 1'b0;
			ls_prev_reg <= 1'b0;
			us_prev_reg <= 1'b0;
			mode_reg    <= MODE_RESET;
			ext_reg     <= EXT_RESET;
			term_reg    <= 1'b0;
			open_reg    <= '0;
			store_ready_reg <= 1'b0;
		end
		else
		begin
			ck_prev_reg <= ck_s;
			ls_prev_reg <= ls_lvl;
			us_prev_reg <= us_lvl;
			term_reg    <= term_next;
			open_reg    <= open_next;
			store_ready_reg <= fifo_in_ready;
			if (is_mode && ba_s == SEL_BASE_MODE)
				mode_reg <= addr_s;
			if (is_mode && ba_s == SEL_EXT_ONE)
				ext_reg <= addr_s;
		end
	end

	// Burst sequencing for both directions
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg   <= ST_IDLE;
			beat_reg    <= 4'h0;
			col_reg     <= '0;
			lo_seen_reg <= 1'b0;
			hi_seen_reg <= 1'b0;
			lo_mask_reg <= 1'b0;
			hi_mask_reg <= 1'b0;
			lo_hold_reg <= 8'h00;
			hi_hold_reg <= 8'h00;
		end
		else
		begin
			lo_hold_reg <= lo_byte;
			hi_hold_reg <= hi_byte;
			lo_mask_reg <= lo_m;
			hi_mask_reg <= hi_m;
			lo_seen_reg <= lo_seen && !beat_take;
			hi_seen_reg <= hi_seen && !beat_take;
			case (state_reg)
				ST_IDLE:
				begin
					beat_reg <= 4'h0;
					if (is_wr || is_rd)
						col_reg <= addr_s[COL_W-1:0];
					if (is_wr)
						state_reg <= ST_WRITE;
					else if (is_rd)
						state_reg <= ST_READ;
				end
				ST_WRITE:
				begin
					if (wr_last)
						state_reg <= ST_IDLE;
					if (beat_take)
						beat_reg <= beat_reg + 4'h1;
				end
				ST_READ:
				begin
					if (rd_end)
						state_reg <= ST_IDLE;
					if (rd_beat)
						beat_reg <= beat_reg + 4'h1;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Read drive: strobe idles low as preamble, then toggles with every data beat
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			strobe_reg      <= 1'b0;
			strobe_oe_reg   <= 1'b0;
			strobe_n_oe_reg <= 1'b0;
			dq_oe_reg       <= 1'b0;
			dq_out_reg      <= 16'h0000;
			rd_next_reg     <= 1'b0;
		end
		else
		begin
			rd_next_reg <= rd_beat;
			if (is_rd)
			begin
				strobe_reg      <= 1'b0;
				strobe_oe_reg   <= 1'b1;
				strobe_n_oe_reg <= !single_se;
			end
			else if (rd_beat)
			begin
				strobe_reg <= !strobe_reg;
				dq_out_reg <= rd_data;
				dq_oe_reg  <= 1'b1;
			end
			else if (rd_end || !in_rd)
			begin
				strobe_oe_reg   <= 1'b0;
				strobe_n_oe_reg <= 1'b0;
				dq_oe_reg       <= 1'b0;
			end
		end
	end

	ddrpi_fifo #(
		.WIDTH (DQ_W + 2),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_w),
		.in_ready  (fifo_in_ready),
		.in_data   ({byte_en, hi_byte, lo_byte}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_byte_en, wr_data})
	);

	// One termination flag serves every data, strobe and mask line of the x16 part
	assign termination_on          = term_reg;
	assign bank_open               = open_reg;
	assign mode_value              = mode_reg;
	assign ext_one_value           = ext_reg;
	assign burst_column            = col_reg;
	assign store_ready             = store_ready_reg;
	assign dq_out                  = dq_out_reg;
	assign dq_oe                   = dq_oe_reg;
	assign lower_data_strobe_out   = strobe_reg;
	assign upper_data_strobe_out   = strobe_reg;
	assign lower_data_strobe_n_out = !strobe_reg;
	assign upper_data_strobe_n_out = !strobe_reg;
	assign lower_data_strobe_oe    = strobe_oe_reg;
	assign upper_data_strobe_oe    = strobe_oe_reg;
	assign lower_data_strobe_n_oe  = strobe_n_oe_reg;
	assign upper_data_strobe_n_oe  = strobe_n_oe_reg;
	assign rd_next                 = rd_next_reg;

	odt_follow_a: assert property (@(posedge clk) disable iff (rst)
		ck_rise && odt_s && term_en |=> termination_on)
		else $error("termination did not follow control");
	rtt_off_a: assert property (@(posedge clk) disable iff (rst)
		!term_en |=> !termination_on)
		else $error("termination on while disabled");
	cs_mask_a: assert property (@(posedge clk) disable iff (rst)
		ck_rise && cs_s |=> $stable(bank_open) && $stable(mode_value) && $stable(ext_one_value))
		else $error("deselected command changed state");
	mask_drop_a: assert property (@(posedge clk) disable iff (rst)
		beat_take && lo_m && hi_m |-> !push_w)
		else $error("masked beat stored");
	act_open_a: assert property (@(posedge clk) disable iff (rst)
		is_act |=> bank_open[$past(ba_s)])
		else $error("activate did not open bank");
	mode_ext_a: assert property (@(posedge clk) disable iff (rst)
		is_mode && ba_s == SEL_EXT_ONE |=> ext_one_value == $past(addr_s) && $stable(mode_value))
		else $error("extended mode write misrouted");
	pre_all_a: assert property (@(posedge clk) disable iff (rst)
		is_pre && pre_all |=> bank_open == '0)
		else $error("precharge all left a bank open");
	pre_one_a: assert property (@(posedge clk) disable iff (rst)
		is_pre && !pre_all |=> !bank_open[$past(ba_s)])
		else $error("single precharge missed bank");
	rd_strobe_a: assert property (@(posedge clk) disable iff (rst)
		rd_beat |=> $changed(lower_data_strobe_out) && dq_oe && lower_data_strobe_oe)
		else $error("read strobe not toggled with data");
	diff_strobe_a: assert property (@(posedge clk) disable iff (rst)
		is_rd |=> lower_data_strobe_n_oe == !$past(single_se))
		else $error("complement strobe mode wrong");
	bus_owner_a: assert property (@(posedge clk) disable iff (rst)
		dq_oe |-> $past(state_reg == ST_READ))
		else $error("data driven outside read");
endmodule

//--- ddrpi_ctl_model.sv
// Controller-side model of the x16 memory pin interface: link clock, commands, write beats.
// Assumes the device outputs come straight from the block; resolves the shared data and strobe lines.
`timescale 1ns/1ps
module ddrpi_ctl_model
	import ddrpi_pkg::*;
(
	input  wire logic              clk,
	output logic                   ck_pin,
	output logic                   cke_pin,
	output logic                   cs_n_pin,
	output logic                   ras_n_pin,
	output logic                   cas_n_pin,
	output logic                   we_n_pin,
	output logic      [BANK_W-1:0] bank_select,
	output logic      [ADDR_W-1:0] addr_pin,
	output logic                   termination_control,
	output logic                   lower_byte_write_mask,
	output logic                   upper_byte_write_mask,
	output logic      [DQ_W-1:0]   dq_in,
	input  wire logic [DQ_W-1:0]   dq_out,
	input  wire logic              dq_oe,
	output logic      [3:0]        strobe_in,
	input  wire logic [3:0]        strobe_out,
	input  wire logic [3:0]        strobe_oe
);
	logic [DQ_W-1:0] dq_drv;
	logic [DQ_W-1:0] dq_idle;
	logic            dq_en;
	logic            st_en;
	logic            st_lvl;
	wire  [3:0]      st_ctl = {~st_lvl, st_lvl, ~st_lvl, st_lvl};
	// Released strobe pairs rest at preamble level; a toggling idle would fake write beats
	wire  [3:0]      st_mix = st_en ? st_ctl : 4'b1010;

	// Released data lines flip every cycle so a stale value never passes for data
	assign dq_in     = dq_oe ? dq_out : (dq_en ? dq_drv : dq_idle);
	assign strobe_in = (strobe_oe & strobe_out) | (~strobe_oe & st_mix);

	initial
	begin
		ck_pin = 1'b0;
		cke_pin = 1'b1;
		{cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hF;
		bank_select = '0;
		addr_pin = '0;
		termination_control = 1'b0;
		lower_byte_write_mask = 1'b0;
		upper_byte_write_mask = 1'b0;
		dq_drv = '0;
		dq_idle = '0;
		dq_en = 1'b0;
		st_en = 1'b0;
		st_lvl = 1'b0;
	end

	always @(posedge clk)
	begin
		dq_idle <= ~dq_in;
	end

	// One link period of 17 clk; pins held well around the rise
	task automatic cmd(input logic [3:0] code, input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] a,
		input logic term, input logic gate);
	begin
		@(posedge clk);
		{cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= code;
		bank_select <= ba;
		addr_pin <= a;
		termination_control <= term;
		cke_pin <= gate;
		repeat (4) @(posedge clk);
		ck_pin <= 1'b1;
		repeat (8) @(posedge clk);
		ck_pin <= 1'b0;
		{cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= 4'hF;
		repeat (4) @(posedge clk);
		cke_pin <= 1'b1;
	end
	endtask

	// Link clock runs on only while read beats are due
	task automatic run_ck(input int edges);
	begin
		repeat (edges)
		begin
			repeat (8) @(posedge clk);
			ck_pin <= ~ck_pin;
		end
		repeat (8) @(posedge clk);
	end
	endtask

	task automatic wr_beat(input logic [DQ_W-1:0] d, input logic lm, input logic um);
	begin
		@(posedge clk);
		dq_drv <= d;
		lower_byte_write_mask <= lm;
		upper_byte_write_mask <= um;
		dq_en <= 1'b1;
		st_en <= 1'b1;
		repeat (3) @(posedge clk);
		st_lvl <= ~st_lvl;
		repeat (3) @(posedge clk);
	end
	endtask

	task automatic wr_end;
	begin
		@(posedge clk);
		dq_en <= 1'b0;
		st_en <= 1'b0;
		st_lvl <= 1'b0;
		lower_byte_write_mask <= 1'b0;
		upper_byte_write_mask <= 1'b0;
	end
	endtask
endmodule

//--- tb_ddr2_command_data_pin_interface.sv
// Self-checking bench for the device pin logic with a controller model on the far side.
// Assumes the write FIFO depth is 8 and that rd_data may change one clk after rd_next.
`timescale 1ns/1ps
module tb_ddr2_command_data_pin_interface;
	import ddrpi_pkg::*;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              wr_ready = 1'b0;
	logic [DQ_W-1:0]   rd_data = 16'hA000;
	logic              diff_exp = 1'b1;
	int                bad_count = 0;
	int                n_checks = 0;
	int                rd_seen = 0;
	logic [17:0]       exp_q[$];
	logic              ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, termination_control;
	logic              lower_byte_write_mask, upper_byte_write_mask, dq_oe, termination_on, store_ready;
	logic              lower_data_strobe_out, lower_data_strobe_oe, lower_data_strobe_n_out, lower_data_strobe_n_oe;
	logic              upper_data_strobe_out, upper_data_strobe_oe, upper_data_strobe_n_out, upper_data_strobe_n_oe;
	logic              wr_valid, rd_next;
	logic [BANK_W-1:0] bank_select;
	logic [ADDR_W-1:0] addr_pin, mode_value, ext_one_value;
	logic [DQ_W-1:0]   dq_in, dq_out, wr_data;
	logic [3:0]        s_in, bank_open;
	logic [COL_W-1:0]  burst_column;
	logic [1:0]        wr_byte_en;

	always #5 clk = ~clk;

	ddrpi_pin_interface #(.FIFO_DEPTH(8)) i_ddrpi_pin_interface (.clk, .rst, .ck_pin, .cke_pin, .cs_n_pin,
		.ras_n_pin, .cas_n_pin, .we_n_pin, .bank_select, .addr_pin, .termination_control, .lower_byte_write_mask,
		.upper_byte_write_mask, .dq_in, .dq_out, .dq_oe, .lower_data_strobe_in(s_in[0]), .lower_data_strobe_out,
		.lower_data_strobe_oe, .lower_data_strobe_n_in(s_in[1]), .lower_data_strobe_n_out, .lower_data_strobe_n_oe,
		.upper_data_strobe_in(s_in[2]), .upper_data_strobe_out, .upper_data_strobe_oe,
		.upper_data_strobe_n_in(s_in[3]), .upper_data_strobe_n_out, .upper_data_strobe_n_oe, .termination_on,
		.bank_open, .mode_value, .ext_one_value, .burst_column, .store_ready, .wr_valid, .wr_ready, .wr_data,
		.wr_byte_en, .rd_data, .rd_next);

	ddrpi_ctl_model i_ddrpi_ctl_model (.clk, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
		.bank_select, .addr_pin, .termination_control, .lower_byte_write_mask, .upper_byte_write_mask, .dq_in,
		.dq_out, .dq_oe, .strobe_in(s_in),
		.strobe_out({upper_data_strobe_n_out, upper_data_strobe_out, lower_data_strobe_n_out, lower_data_strobe_out}),
		.strobe_oe({upper_data_strobe_n_oe, upper_data_strobe_oe, lower_data_strobe_n_oe, lower_data_strobe_oe}));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic final_report;
	begin
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task automatic link(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a, input logic t, input logic g);
	begin
		i_ddrpi_ctl_model.cmd(code, ba, a, t, g);
	end
	endtask

	// Expected words assume no pops during the burst, so capacity is plain queue length
	task automatic wr_burst(input logic [15:0] base, input logic [7:0] lm, input logic [7:0] um);
		logic [15:0] d;
	begin
		for (int i = 0; i < 8; i++)
		begin
			d = base + 16'(i);
			i_ddrpi_ctl_model.wr_beat(d, lm[i], um[i]);
			if (!(lm[i] && um[i]) && exp_q.size() < 8)
				exp_q.push_back({~um[i], ~lm[i], d & {{8{~um[i]}}, {8{~lm[i]}}}});
		end
		i_ddrpi_ctl_model.wr_end();
	end
	endtask

	always @(posedge clk)
	begin
		if (rd_next)
		begin
			chk(dq_out, 16'hA000 + rd_seen[15:0]);
			chk({dq_oe, upper_data_strobe_out, upper_data_strobe_n_oe, diff_exp ? lower_data_strobe_n_out :
				~lower_data_strobe_out}, {1'b1, lower_data_strobe_out, diff_exp, ~lower_data_strobe_out});
			rd_seen <= rd_seen + 1;
			rd_data <= 16'hA001 + rd_seen[15:0];
		end
		if (wr_valid && wr_ready)
			chk({wr_byte_en, wr_data & {{8{wr_byte_en[1]}}, {8{wr_byte_en[0]}}}},
				exp_q.size() > 0 ? exp_q.pop_front() : 18'h0);
		if (i_ddrpi_ctl_model.dq_en)
			chk(dq_oe, 0);
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		$display("watchdog expired at %0t ns", $time);
		bad_count++;
		final_report();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk({termination_on, bank_open, dq_oe, store_ready}, 7'h01);
		chk({mode_value, ext_one_value}, {MODE_RESET, EXT_RESET});
		$display("test reset done");
		link(CMD_MODE_SET, SEL_BASE_MODE, {10'h000, BURST_CODE_8}, 1'b0, 1'b1);
		link(CMD_MODE_SET, SEL_EXT_ONE, 13'h0004, 1'b0, 1'b1);
		link(CMD_MODE_SET, 2'h2, 13'h1FFF, 1'b0, 1'b1);
		chk({mode_value, ext_one_value}, {13'h0003, 13'h0004});
		$display("test mode set done");
		link(4'hF, 2'h0, 13'h0000, 1'b1, 1'b1);
		chk(termination_on, 1);
		link(4'hF, 2'h0, 13'h0000, 1'b0, 1'b1);
		chk(termination_on, 0);
		link(CMD_MODE_SET, SEL_EXT_ONE, 13'h0000, 1'b1, 1'b1);
		link(4'hF, 2'h0, 13'h0000, 1'b1, 1'b1);
		chk(termination_on, 0);
		link(CMD_MODE_SET, SEL_EXT_ONE, 13'h0040, 1'b1, 1'b1);
		link(4'hF, 2'h0, 13'h0000, 1'b1, 1'b1);
		chk(termination_on, 1);
		link(4'hF, 2'h0, 13'h0000, 1'b0, 1'b1);
		$display("test termination done");
		link(CMD_ACTIVATE | 4'h8, 2'h1, 13'h1ABC, 1'b0, 1'b1);
		link(CMD_ACTIVATE, 2'h2, 13'h1ABC, 1'b0, 1'b0);
		chk(bank_open, 4'h0);
		for (int b = 0; b < 4; b++)
		begin
			link(CMD_ACTIVATE, 2'(b), 13'h1ABC, 1'b0, 1'b1);
			chk(bank_open, (32'h2 << b) - 32'h1);
		end
		link(CMD_PRECHARGE, 2'h2, 13'h0000, 1'b0, 1'b1);
		chk(bank_open, 4'hB);
		link(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b0, 1'b1);
		chk(bank_open, 4'h0);
		$display("test banks done");
		link(CMD_ACTIVATE, 2'h1, 13'h0010, 1'b0, 1'b1);
		link(CMD_WRITE, 2'h1, 13'h0415, 1'b0, 1'b1);
		wr_burst(16'h1100, 8'h24, 8'h44);
		chk({bank_open, burst_column}, {4'h0, 9'h015});
		link(CMD_ACTIVATE, 2'h2, 13'h0010, 1'b0, 1'b1);
		link(CMD_WRITE, 2'h2, 13'h0008, 1'b0, 1'b1);
		wr_burst(16'h2200, 8'h00, 8'h00);
		chk(store_ready, 0);
		wr_ready <= 1'b1;
		repeat (20) @(posedge clk);
		chk({store_ready, 4'(exp_q.size())}, 5'h10);
		wr_ready <= 1'b0;
		$display("test write done");
		link(CMD_READ, 2'h2, 13'h0007, 1'b0, 1'b1);
		i_ddrpi_ctl_model.run_ck(8);
		chk({rd_seen[7:0], dq_oe, lower_data_strobe_oe, burst_column}, {8'h08, 2'b00, 9'h007});
		link(CMD_MODE_SET, SEL_EXT_ONE, 13'h0400, 1'b0, 1'b1);
		link(CMD_MODE_SET, SEL_BASE_MODE, 13'h0002, 1'b0, 1'b1);
		diff_exp <= 1'b0;
		link(CMD_READ, 2'h2, 13'h0007, 1'b0, 1'b1);
		i_ddrpi_ctl_model.run_ck(4);
		chk({rd_seen[7:0], dq_oe}, 9'h018);
		$display("test read done");
		final_report();
	end
endmodule
